// ### src/mcp_config_regs.v
// Configuration and pulse output control registers of the metering device
`include "mcp_consts.vh"
module mcp_config_regs #(
  parameter [31:0] SETTLE0_CYC = `MCP_SETTLE0_CYC,
  parameter [31:0] SETTLE1_CYC = `MCP_SETTLE1_CYC,
  parameter [31:0] SETTLE2_CYC = `MCP_SETTLE2_CYC
) (
  input  wire                    clk_sys,
  input  wire                    sys_rst,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  input  wire [`MCP_ADDR_W-1:0]  reg_addr,
  input  wire [15:0]             reg_wdata,
  output reg  [15:0]             reg_rdata,
  output reg                     reg_rvalid,
  output wire                    burst_allowed,
  output wire                    checksum_append,
  input  wire                    irq_group_a,
  input  wire                    irq_group_b,
  output wire                    interrupt_pin_a,
  output wire                    interrupt_pin_b,
  output wire                    outside_reference_select,
  input  wire                    converter_restart,
  output wire                    accumulate_enable,
  output reg                     pulse_accumulator_clear,
  output reg                     soft_reset_trigger,
  input  wire [3:0]              converter_pulse,
  input  wire [3:0]              converter_pulse_event,
  input  wire                    event_signal,
  input  wire                    zero_cross_signal,
  output reg                     pulse_pin_4,
  output reg                     pulse_pin_3,
  output reg                     pulse_pin_2,
  output reg                     pulse_pin_1,
  output wire [3:0]              pulse_status_set,
  output wire                    pulse_pin4_reserved
);
  reg  [15:0] gen_cfg_q;
  reg  [15:0] pulse_mode_q;
  wire [3:0]  pulse_disable;
  wire        wr_gen;
  wire        wr_mode;
  wire [1:0]  pin4_fn;
  wire        burst_en;
  wire        irq_combine;
  wire        pin3_alt;
  wire [1:0]  settle_sel;
  wire        settle_restart;
  reg  [3:0]  pin_d;

  // Address match, used for both read and write decode
  function hit;
    input [`MCP_ADDR_W-1:0] a;
    input [`MCP_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Pin 4 code compare, shared by the pin mux and the reserved flag
  function pin4_is;
    input [1:0] fn;
    input [1:0] code;
    begin
      pin4_is = (fn == code);
    end
  endfunction

  assign wr_gen        = reg_wr && hit(reg_addr, `MCP_OFF_GEN_CFG);
  assign wr_mode       = reg_wr && hit(reg_addr, `MCP_OFF_PULSE_MODE);
  assign pulse_disable = pulse_mode_q[15:12];
  assign pin4_fn       = gen_cfg_q[`MCP_PIN4_HI:`MCP_PIN4_LO];
  assign burst_en      = gen_cfg_q[`MCP_BIT_BURST];
  assign irq_combine   = gen_cfg_q[`MCP_BIT_IRQ_COMBINE];
  assign pin3_alt      = gen_cfg_q[`MCP_BIT_PIN3_FN];
  assign settle_sel    = gen_cfg_q[`MCP_SETTLE_HI:`MCP_SETTLE_LO];

  // Stored bits; reserved and write-only positions never hold a value
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      gen_cfg_q    <= 16'h0000;
      pulse_mode_q <= 16'h0000;
    end
    else
    begin
      if (wr_gen)
        gen_cfg_q <= reg_wdata & `MCP_GEN_CFG_RW_MASK;
      if (wr_mode)
        pulse_mode_q <= reg_wdata & `MCP_PULSE_MODE_MASK;
    end
  end

  // Self-clearing strobes: one-cycle pulses, bits read back as zero
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pulse_accumulator_clear <= 1'b0;
      soft_reset_trigger      <= 1'b0;
    end
    else
    begin
      pulse_accumulator_clear <= wr_gen && reg_wdata[`MCP_BIT_ACC_CLR];
      soft_reset_trigger      <= wr_gen && reg_wdata[`MCP_BIT_SOFT_RST];
    end
  end

  // Read port: one cycle latency, unmapped addresses return zero
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        if (hit(reg_addr, `MCP_OFF_GEN_CFG))
          reg_rdata <= gen_cfg_q & `MCP_GEN_CFG_RW_MASK;
        else if (hit(reg_addr, `MCP_OFF_PULSE_MODE))
          reg_rdata <= pulse_mode_q;
        else
          reg_rdata <= 16'h0000;
      end
    end
  end

  // Serial port controls derived from the burst bit
  assign burst_allowed   = burst_en && (reg_addr >= `MCP_BURST_LO)
                           && (reg_addr <= `MCP_BURST_HI);
  assign checksum_append = ~burst_en;

  // Interrupt pins are active high here; combine folds group a onto pin b
  assign interrupt_pin_a = irq_group_a;
  assign interrupt_pin_b = irq_group_b | (irq_combine & irq_group_a);

  assign outside_reference_select = gen_cfg_q[`MCP_BIT_OUTSIDE_REFERENCE_SELECT];
  assign pulse_pin4_reserved      = pin4_is(pin4_fn, `MCP_PIN4_RSVD);

  // Any restart source rearms the wait; a settle field change alone does not
  assign settle_restart = converter_restart | pulse_accumulator_clear | soft_reset_trigger;

  // Wait counted in plain clock cycles, so long settings need a wide counter
  mcp_settle_timer #(
    .CYC0 (SETTLE0_CYC),
    .CYC1 (SETTLE1_CYC),
    .CYC2 (SETTLE2_CYC)
  ) u_settle (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .restart    (settle_restart),
    .settle_sel (settle_sel),
    .settled_q  (accumulate_enable)
  );

  // Status flags are suppressed per disabled output
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_stat
      assign pulse_status_set[g] = converter_pulse_event[g] & ~pulse_disable[g];
    end
  endgenerate

  // Next pin levels; disabled pins and the reserved pin 4 code idle high
  always @*
  begin
    pin_d = 4'hf;
    if (!pulse_disable[0])
      pin_d[0] = converter_pulse[0];
    if (!pulse_disable[1])
      pin_d[1] = converter_pulse[1];
    if (pulse_disable[2])
      pin_d[2] = 1'b1;
    else if (pin3_alt)
      pin_d[2] = zero_cross_signal;
    else
      pin_d[2] = converter_pulse[2];
    if (pulse_disable[3])
      pin_d[3] = 1'b1;
    else if (pin4_is(pin4_fn, `MCP_PIN4_EVENT))
      pin_d[3] = event_signal;
    else if (pin4_is(pin4_fn, `MCP_PIN4_RSVD))
      pin_d[3] = 1'b1;
    else
      pin_d[3] = converter_pulse[3];
  end

  // Pins registered so a mux change never glitches a pin
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pulse_pin_1 <= 1'b1;
      pulse_pin_2 <= 1'b1;
      pulse_pin_3 <= 1'b1;
      pulse_pin_4 <= 1'b1;
    end
    else
    begin
      pulse_pin_1 <= pin_d[0];
      pulse_pin_2 <= pin_d[1];
      pulse_pin_3 <= pin_d[2];
      pulse_pin_4 <= pin_d[3];
    end
  end
endmodule

// ### src/mcp_consts.vh
// Register offsets, field positions and timing counts for the meter config block
`ifndef MCP_CONSTS_VH
`define MCP_CONSTS_VH
`define MCP_ADDR_W            12
`define MCP_OFF_GEN_CFG       12'h481
`define MCP_OFF_PULSE_MODE    12'h490
`define MCP_GEN_CFG_MASK      16'h9b2f
`define MCP_GEN_CFG_RW_MASK   16'h9b0e
`define MCP_PULSE_MODE_MASK   16'hf000
`define MCP_BIT_OUTSIDE_REFERENCE_SELECT       15
`define MCP_BIT_IRQ_COMBINE   12
`define MCP_BIT_BURST         11
`define MCP_SETTLE_HI         9
`define MCP_SETTLE_LO         8
`define MCP_BIT_ACC_CLR       5
`define MCP_PIN4_HI           3
`define MCP_PIN4_LO           2
`define MCP_BIT_PIN3_FN       1
`define MCP_BIT_SOFT_RST      0
`define MCP_BIT_DIS_LO        12
`define MCP_BURST_LO          12'h500
`define MCP_BURST_HI          12'h6ff
`define MCP_PIN4_EVENT        2'h2
`define MCP_PIN4_RSVD         2'h3
`define MCP_CLK_KHZ           125000
`define MCP_SETTLE0_MS        64
`define MCP_SETTLE1_MS        128
`define MCP_SETTLE2_MS        256
`define MCP_SETTLE0_CYC       (`MCP_SETTLE0_MS * `MCP_CLK_KHZ)
`define MCP_SETTLE1_CYC       (`MCP_SETTLE1_MS * `MCP_CLK_KHZ)
`define MCP_SETTLE2_CYC       (`MCP_SETTLE2_MS * `MCP_CLK_KHZ)
`endif

// ### src/mcp_settle_timer.v
// Settle delay counter gating the start of accumulation
`include "mcp_consts.vh"
module mcp_settle_timer #(
  parameter [31:0] CYC0 = `MCP_SETTLE0_CYC,
  parameter [31:0] CYC1 = `MCP_SETTLE1_CYC,
  parameter [31:0] CYC2 = `MCP_SETTLE2_CYC
) (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       restart,
  input  wire [1:0] settle_sel,
  output reg        settled_q
);
  reg  [31:0] count_q;
  reg  [31:0] limit;

  // Pick the wait length from the settle field
  always @*
  begin
    case (settle_sel)
      2'h0:    limit = CYC0;
      2'h1:    limit = CYC1;
      2'h2:    limit = CYC2;
      default: limit = 32'h0;
    endcase
  end

  // Count up after restart; code 3 settles on the first cycle after restart, like a limit of 1
  always @(posedge clk_sys)
  begin
    if (sys_rst || restart)
    begin
      count_q   <= 32'h0;
      settled_q <= 1'b0;
    end
    else if (!settled_q)
    begin
      if (count_q + 32'h1 >= limit)
        settled_q <= 1'b1;
      count_q <= count_q + 32'h1;
    end
  end
endmodule

// ### tb/mcp_cfg_sva.sv
// Port assertions for the meter configuration block
`include "mcp_consts.vh"
module mcp_cfg_sva (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        burst_allowed,
  input wire logic        checksum_append,
  input wire logic        irq_group_a,
  input wire logic        interrupt_pin_a,
  input wire logic        outside_reference_select,
  input wire logic        pulse_accumulator_clear,
  input wire logic        soft_reset_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Decoded accesses to the general register
  wire logic gen_wr = reg_wr && reg_addr == `MCP_OFF_GEN_CFG;
  wire logic gen_rd = reg_rd && reg_addr == `MCP_OFF_GEN_CFG;
  // Self-clearing strobes: high one cycle, then low
  sequence s_clr;
    pulse_accumulator_clear ##1 !pulse_accumulator_clear;
  endsequence
  sequence s_srst;
    soft_reset_trigger ##1 !soft_reset_trigger;
  endsequence
  property p_clr;
    gen_wr && reg_wdata[5] ##1 !(gen_wr && reg_wdata[5]) |-> s_clr;
  endproperty
  a_clr: assert property (p_clr) else $error("clear strobe wrong");
  property p_srst;
    gen_wr && reg_wdata[0] ##1 !(gen_wr && reg_wdata[0]) |-> s_srst;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset strobe wrong");
  property p_ref;
    gen_wr |=> outside_reference_select == $past(reg_wdata[15]);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_crc;
    gen_wr |=> checksum_append == !$past(reg_wdata[11]);
  endproperty
  a_crc: assert property (p_crc) else $error("checksum append wrong");
  property p_burst;
    burst_allowed |-> reg_addr >= `MCP_BURST_LO && reg_addr <= `MCP_BURST_HI;
  endproperty
  a_burst: assert property (p_burst) else $error("burst out of range");
  property p_rsv;
    gen_rd |=> (reg_rdata & ~`MCP_GEN_CFG_RW_MASK) == 16'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read set");
  property p_unmap;
    reg_rd && reg_addr != `MCP_OFF_GEN_CFG && reg_addr != `MCP_OFF_PULSE_MODE |=> reg_rdata == 16'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_irq_a;
    interrupt_pin_a == irq_group_a;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("interrupt pin a wrong");
endmodule
bind mcp_config_regs mcp_cfg_sva u_sva (.*);

// ### tb/mcp_host.sv
// Host model issuing register strobes
module mcp_host (
  input  wire logic        clk_sys,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [11:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // Data is scrambled after a write so stale values cannot pass
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    d = reg_rvalid === 1'b1 ? reg_rdata : 16'hxxxx;
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the meter configuration block
`include "mcp_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, reg_rvalid, burst_allowed, checksum_append;
  logic        irq_group_a, irq_group_b, interrupt_pin_a, interrupt_pin_b, outside_reference_select;
  logic        converter_restart, accumulate_enable, pulse_accumulator_clear, soft_reset_trigger;
  logic        event_signal, zero_cross_signal, pulse_pin_4, pulse_pin_3, pulse_pin_2, pulse_pin_1;
  logic        pulse_pin4_reserved;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [3:0]  converter_pulse, converter_pulse_event, pulse_status_set;
  int          mismatches, checked;
  int          cyc = 0;
  mcp_config_regs #(.SETTLE0_CYC(10), .SETTLE1_CYC(20), .SETTLE2_CYC(40)) dut (.*);
  mcp_host h (.*);
  initial
  begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_regs;
    h.rd(`MCP_OFF_GEN_CFG, d);
    chk("gen reset", 16'h0, d);
    h.wr(`MCP_OFF_GEN_CFG, 16'hffff);
    chk("strobes", 2'h3, {pulse_accumulator_clear, soft_reset_trigger});
    h.rd(`MCP_OFF_GEN_CFG, d);
    chk("strobes off", 2'h0, {pulse_accumulator_clear, soft_reset_trigger});
    chk("gen bits", 16'h9b0e, d);
    chk("ref", 1'b1, outside_reference_select);
    h.wr(`MCP_OFF_PULSE_MODE, 16'hffff);
    h.rd(`MCP_OFF_PULSE_MODE, d);
    chk("mode bits", 16'hf000, d);
    h.rd(12'h482, d);
    chk("unmapped", 16'h0, d);
  endtask
  task automatic t_burst;
    logic [11:0] a [4] = '{12'h4ff, 12'h500, 12'h6ff, 12'h700};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      #1;
      h.reg_addr = a[i];
      @(negedge clk_sys);
      chk("burst", i == 1 || i == 2, burst_allowed);
    end
    chk("crc off", 1'b0, checksum_append);
    h.wr(`MCP_OFF_GEN_CFG, 16'h0);
    h.reg_addr = 12'h500;
    @(negedge clk_sys);
    chk("burst off", 1'b0, burst_allowed);
    chk("crc on", 1'b1, checksum_append);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      if (i[1:0] == 2'h0)
        h.wr(`MCP_OFF_GEN_CFG, {3'h0, i[2], 12'h0});
      @(posedge clk_sys);
      #1;
      {irq_group_a, irq_group_b} = i[1:0];
      @(negedge clk_sys);
      chk("irq a", irq_group_a, interrupt_pin_a);
      chk("irq b", irq_group_b | (i[2] & irq_group_a), interrupt_pin_b);
    end
  endtask
  task automatic t_pins;
    h.wr(`MCP_OFF_PULSE_MODE, 16'h0000);
    {converter_pulse, event_signal, zero_cross_signal} = 6'h03;
    for (int k = 0; k < 4; k++)
    begin
      h.wr(`MCP_OFF_GEN_CFG, {12'h0, k[1:0], k[0], 1'b0});
      @(posedge clk_sys);
      #1;
      chk("pin4", k[1], pulse_pin_4);
      chk("pin4 rsvd", k == 3, pulse_pin4_reserved);
      chk("pin3", k[0], pulse_pin_3);
    end
    h.wr(`MCP_OFF_GEN_CFG, 16'h0000);
    for (int j = 0; j < 4; j++)
    begin
      h.wr(`MCP_OFF_PULSE_MODE, 16'h1000 << j);
      converter_pulse_event = 4'hf;
      @(posedge clk_sys);
      #1;
      chk("pins", 4'h1 << j, {pulse_pin_4, pulse_pin_3, pulse_pin_2, pulse_pin_1});
      chk("status", 4'(~(4'h1 << j)), pulse_status_set);
      converter_pulse_event = 4'h0;
    end
  endtask
  task automatic t_settle;
    int n;
    int e [6] = '{10, 20, 40, 0, 10, 10};
    for (int s = 0; s < 6; s++)
    begin
      if (s == 5)
      begin
        @(posedge clk_sys);
        #1;
        converter_restart = 1'b1;
        @(posedge clk_sys);
        #1;
        converter_restart = 1'b0;
      end
      else
      begin
        h.wr(`MCP_OFF_GEN_CFG, s == 4 ? 16'h0001 : {6'h0, s[1:0], 8'h20});
        repeat (2) @(posedge clk_sys);
        #1;
      end
      n = 0;
      while (accumulate_enable !== 1'b1 && n < 100)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("settle", 1'b1, n >= e[s] - 2 && n <= e[s] + 3);
    end
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      report_and_stop;
    end
  end
  initial
  begin
    {sys_rst, irq_group_a, irq_group_b, converter_restart, event_signal, zero_cross_signal} = 6'h20;
    {converter_pulse, converter_pulse_event, mismatches, checked} = '0;
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 0;
    t_regs;
    t_burst;
    t_irq;
    t_pins;
    t_settle;
    report_and_stop;
  end
endmodule
